// File: design/spf_top.sv
// Basic-parameter and fieldbus fault-policy logic of a motor starter
// What this block does
// - Self-protection trip switches motor and brake off, raises overload
// - After a self-protection trip, emergency start cannot switch on
// - Current thresholds are percent of rated current, rated is 100
// - Rated current 0.15-2 A or 1.5-12 A by class, 10 mA steps
// - Rated current resets to the top of its range
// - Without parameters the rated current stays at its highest value
// - Soft starter in direct startup mode limits rated current to 9 A
// - Single-phase load disables asymmetry detection
// - Three-phase load, the default, enables asymmetry detection
// - Overload kept across electronics supply loss only if protected
// - Switching supply loss gives fault, fault on ON, or warning
// - Master STOP holds last image or substitutes zero, zero default
// - STOP substitution applies only in automatic mode
// - Bus error takes the same response as master STOP
// - Group diagnostics blocked sends no error messages, default enable
// - S1 status bit is one while a group fault is pending and diagnostics are not blocked
// - Any fault gives a fault message and a red group-fault indicator
// - Wait up to 3 minutes for startup data set, else parameter fault
// - Parameter fault clears once startup parameters arrive cleanly
module spf_top #(
   parameter int WAIT_TICKS_P = spf_pkg::WAIT_TICKS,
   parameter int TICK_CYC_P = spf_pkg::TICK_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Device-side pins
   input wire logic self_prot_i,
   input wire logic emerg_start_i,
   input wire logic elec_sup_ok_i,
   input wire logic sw_sup_ok_i,
   input wire logic on_cmd_i,
   input wire logic master_stop_i,
   input wire logic bus_err_i,
   input wire logic [3:0] output_process_image_i,
   output logic [3:0] output_process_image_o,
   output spf_pkg::spf_drive_t drive_o,
   output spf_pkg::spf_diag_t diag_o,
   output logic group_fault_indicator_o
);
   // Two-flop synchronisers for pin inputs
   localparam int NS = 11;
   logic [NS-1:0] sync1_ff;
   logic [NS-1:0] sync2_ff;
   logic [3:0] img1_ff;
   logic [3:0] img2_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         // Supplies read as present, so reset raises no false supply fault
         sync1_ff <= 11'h0c0;
         sync2_ff <= 11'h0c0;
         img1_ff <= 4'h0;
         img2_ff <= 4'h0;
      end else begin
         sync1_ff <= {1'b0, self_prot_i, emerg_start_i, elec_sup_ok_i,
                      sw_sup_ok_i, on_cmd_i, master_stop_i, bus_err_i,
                      3'h0};
         sync2_ff <= sync1_ff;
         img1_ff <= output_process_image_i;
         img2_ff <= img1_ff;
      end
   end
   logic s_prot, s_emerg, s_elec_ok, s_sw_ok, s_on, s_stop, s_berr;
   assign s_prot = sync2_ff[9];
   assign s_emerg = sync2_ff[8];
   assign s_elec_ok = sync2_ff[7];
   assign s_sw_ok = sync2_ff[6];
   assign s_on = sync2_ff[5];
   assign s_stop = sync2_ff[4];
   assign s_berr = sync2_ff[3];

   // Registers
   logic [11:0] ctrl_ff;
   logic [10:0] rated_ff;
   logic [15:0] thresh_ff;
   logic [10:0] rated_max;
   logic [10:0] rated_min;
   logic [10:0] wr_rated;

   // AHB address phase capture
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] addr_ff;
   logic take;
   assign take = hsel_i && hready_i && htrans_i[1];
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= take && hwrite_i;
         rd_pend_ff <= take && !hwrite_i;
         if (take) begin
            addr_ff <= haddr_i;
         end
      end
   end
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // Range of rated current by output class and startup mode
   always_comb begin
      if (ctrl_ff[spf_pkg::CTRL_HIGH_CLASS]) begin
         rated_min = spf_pkg::RATED_HI_MIN;
         rated_max = ctrl_ff[spf_pkg::CTRL_SOFT_DIRECT] ?
                     spf_pkg::RATED_DIRECT_MAX : spf_pkg::RATED_HI_MAX;
      end else begin
         rated_min = spf_pkg::RATED_LO_MIN;
         rated_max = spf_pkg::RATED_LO_MAX;
      end
   end
   // Out-of-range writes saturate rather than being dropped
   always_comb begin
      wr_rated = hwdata_i[10:0];
      // Whole word compared so large values cannot wrap into range
      if (hwdata_i > 32'(rated_max)) begin
         wr_rated = rated_max;
      end else if (wr_rated < rated_min) begin
         wr_rated = rated_min;
      end
   end

   logic ds_done_pulse;
   logic ds_err_pulse;
   logic class_chg;
   assign class_chg = wr_pend_ff && addr_ff == spf_pkg::REG_CTRL &&
      (hwdata_i[8:7] != ctrl_ff[8:7]);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff <= spf_pkg::CTRL_RST;
      end else if (wr_pend_ff && addr_ff == spf_pkg::REG_CTRL) begin
         // Bits 11:10 are write-one strobes, cleared the cycle after
         ctrl_ff <= hwdata_i[11:0];
      end else begin
         ctrl_ff[11:10] <= 2'b00;
      end
   end
   assign ds_done_pulse = ctrl_ff[spf_pkg::CTRL_DS_DONE];
   assign ds_err_pulse = ctrl_ff[spf_pkg::CTRL_DS_ERR];

   // Rated current: maximum until software parameterises it
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rated_ff <= spf_pkg::RATED_LO_MAX;
      end else if (wr_pend_ff && addr_ff == spf_pkg::REG_RATED) begin
         rated_ff <= wr_rated;
      end else if (class_chg) begin
         rated_ff <= 11'h7ff;
      end else if (rated_ff > rated_max) begin
         rated_ff <= rated_max;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         thresh_ff <= 16'(spf_pkg::PCT_FULL);
      end else if (wr_pend_ff && addr_ff == spf_pkg::REG_THRESH) begin
         thresh_ff <= hwdata_i[15:0];
      end
   end
   // Absolute threshold in 10 mA units: percent of rated current
   logic [26:0] limit_abs;
   assign limit_abs = 27'((32'(thresh_ff) * 32'(rated_ff)) /
                          32'(spf_pkg::PCT_FULL));

   // Self-protection latch, cleared only by reset
   logic sp_trip_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sp_trip_ff <= 1'b0;
      end else if (s_prot) begin
         sp_trip_ff <= 1'b1;
      end
   end

   // Overload message and electronics supply loss
   logic ovl_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ovl_ff <= 1'b0;
      end else if (s_prot) begin
         ovl_ff <= 1'b1;
      end else if (!s_elec_ok && !ctrl_ff[spf_pkg::CTRL_VFAIL_PROT]) begin
         ovl_ff <= 1'b0;
      end
   end

   // Switching-element supply failure
   logic sup_fault_ff;
   logic sup_warn_ff;
   logic on_seen_ff;
   // ON latched during the outage, so a short ON pulse still counts
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         on_seen_ff <= 1'b0;
      end else if (s_sw_ok) begin
         on_seen_ff <= 1'b0;
      end else if (s_on) begin
         on_seen_ff <= 1'b1;
      end
   end
   // Response follows the current setting, so a new setting applies at once
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sup_fault_ff <= 1'b0;
         sup_warn_ff <= 1'b0;
      end else if (s_sw_ok) begin
         sup_fault_ff <= 1'b0;
         sup_warn_ff <= 1'b0;
      end else begin
         unique case (ctrl_ff[3:2])
            spf_pkg::SUP_FAULT: begin
               sup_fault_ff <= 1'b1;
               sup_warn_ff <= 1'b0;
            end
            spf_pkg::SUP_FAULT_ON: begin
               sup_fault_ff <= on_seen_ff || s_on;
               sup_warn_ff <= 1'b0;
            end
            spf_pkg::SUP_WARN: begin
               sup_fault_ff <= 1'b0;
               sup_warn_ff <= 1'b1;
            end
            default: begin
               sup_fault_ff <= 1'b1;
               sup_warn_ff <= 1'b0;
            end
         endcase
      end
   end

   // Startup data set timeout, prescaled
   logic [15:0] pre_ff;
   logic [17:0] tick_cnt_ff;
   logic ds_wait_ff;
   logic param_fault_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pre_ff <= 16'h0000;
         tick_cnt_ff <= 18'h00000;
         ds_wait_ff <= 1'b1;
      end else if (ds_done_pulse) begin
         ds_wait_ff <= 1'b0;
      end else if (ds_wait_ff) begin
         if (pre_ff == 16'(TICK_CYC_P - 1)) begin
            pre_ff <= 16'h0000;
            if (tick_cnt_ff != 18'(WAIT_TICKS_P)) begin
               tick_cnt_ff <= tick_cnt_ff + 18'h00001;
            end
         end else begin
            pre_ff <= pre_ff + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         param_fault_ff <= 1'b0;
      end else if (ds_err_pulse) begin
         // A reported error wins over a done strobe in the same write
         param_fault_ff <= 1'b1;
      end else if (ds_done_pulse) begin
         param_fault_ff <= 1'b0;
      end else if (ctrl_ff[spf_pkg::CTRL_WAIT_DS] && ds_wait_ff &&
                   tick_cnt_ff == 18'(WAIT_TICKS_P)) begin
         param_fault_ff <= 1'b1;
      end
   end

   // Output process image under STOP or bus error
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         output_process_image_o <= 4'h0;
      end else if ((s_stop || s_berr) &&
                   ctrl_ff[spf_pkg::CTRL_AUTO]) begin
         if (!ctrl_ff[spf_pkg::CTRL_STOP_RETAIN]) begin
            output_process_image_o <= 4'h0;
         end
      end else begin
         output_process_image_o <= img2_ff;
      end
   end

   // Drive and diagnostics
   logic fault_any;
   assign fault_any = sp_trip_ff || ovl_ff || sup_fault_ff || param_fault_ff;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         drive_o <= '0;
         diag_o <= '0;
         group_fault_indicator_o <= 1'b0;
      end else begin
         // Trip already latched by s_prot; gate on both to save a cycle
         drive_o.motor_en <= !(s_prot || sp_trip_ff) &&
            (output_process_image_o[0] || s_emerg);
         drive_o.brake_en <= !(s_prot || sp_trip_ff) &&
            output_process_image_o[1];
         drive_o.sw_overload <= s_prot || sp_trip_ff;
         diag_o.group_fault <= fault_any;
         diag_o.group_warn <= sup_warn_ff;
         diag_o.s1 <= fault_any &&
            !ctrl_ff[spf_pkg::CTRL_DIAG_BLOCK];
         diag_o.fault_led_red <= fault_any;
         diag_o.asym_en <= !ctrl_ff[spf_pkg::CTRL_LOAD_1PH];
         diag_o.param_fault <= param_fault_ff;
         group_fault_indicator_o <= fault_any;
      end
   end

   // Read data
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         hrdata_o <= 32'h00000000;
      end else if (take && !hwrite_i) begin
         unique case (haddr_i)
            spf_pkg::REG_CTRL: hrdata_o <= {20'h00000, ctrl_ff};
            spf_pkg::REG_RATED: hrdata_o <= {21'h000000, rated_ff};
            spf_pkg::REG_STAT: hrdata_o <= {24'h000000, ds_wait_ff,
               sp_trip_ff, ovl_ff, sup_fault_ff, sup_warn_ff,
               param_fault_ff, fault_any, !ctrl_ff[spf_pkg::CTRL_LOAD_1PH]};
            spf_pkg::REG_LIMIT: hrdata_o <= {5'h00, limit_abs};
            spf_pkg::REG_IMAGE: hrdata_o <= {28'h0000000,
                                             output_process_image_o};
            spf_pkg::REG_THRESH: hrdata_o <= {16'h0000, thresh_ff};
            default: hrdata_o <= 32'h00000000;
         endcase
      end
   end
endmodule : spf_top

// File: design/spf_pkg.sv
// Package: register map, field layout, reset values and timing constants
package spf_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RATED = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_LIMIT = 8'h0c;
   localparam logic [7:0] REG_IMAGE = 8'h10;
   localparam logic [7:0] REG_THRESH = 8'h14;
   // CTRL field positions
   localparam int CTRL_LOAD_1PH = 0;
   localparam int CTRL_VFAIL_PROT = 1;
   localparam int CTRL_SUP_LO = 2;
   localparam int CTRL_STOP_RETAIN = 4;
   localparam int CTRL_DIAG_BLOCK = 5;
   localparam int CTRL_WAIT_DS = 6;
   localparam int CTRL_HIGH_CLASS = 7;
   localparam int CTRL_SOFT_DIRECT = 8;
   localparam int CTRL_AUTO = 9;
   localparam int CTRL_DS_DONE = 10;
   localparam int CTRL_DS_ERR = 11;
   // Reset of CTRL: 3-phase, protection yes, group fault, substitute, enable,
   // no wait, low class, automatic
   localparam logic [11:0] CTRL_RST = 12'h202;
   // Rated current in 10 mA steps
   localparam logic [10:0] RATED_LO_MIN = 11'd15;
   localparam logic [10:0] RATED_LO_MAX = 11'd200;
   localparam logic [10:0] RATED_HI_MIN = 11'd150;
   localparam logic [10:0] RATED_HI_MAX = 11'd1200;
   localparam logic [10:0] RATED_DIRECT_MAX = 11'd900;
   localparam logic [6:0] PCT_FULL = 7'd100;
   // Supply-fail response codes
   localparam logic [1:0] SUP_FAULT = 2'd0;
   localparam logic [1:0] SUP_FAULT_ON = 2'd1;
   localparam logic [1:0] SUP_WARN = 2'd2;
   // Startup data set wait: 3 minutes, prescaled to 1 ms ticks
   localparam int CLK_HZ = 50_000_000;
   localparam int WAIT_S = 180;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int WAIT_TICKS = WAIT_S * 1000 / TICK_MS;
   localparam logic [3:0] HTRANS_NONSEQ_BIT = 4'h1;

   typedef struct packed {
      logic motor_en;
      logic brake_en;
      logic sw_overload;
   } spf_drive_t;

   typedef struct packed {
      logic group_fault;
      logic group_warn;
      logic s1;
      logic fault_led_red;
      logic asym_en;
      logic param_fault;
   } spf_diag_t;
endpackage : spf_pkg

// File: verif/spf_checker.sv
// Concurrent checks on the ports of the fault-policy block
module spf_checker #(
   parameter int WAIT_TICKS_P = 5,
   parameter int TICK_CYC_P = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic self_prot_i,
   input wire logic emerg_start_i,
   input wire spf_pkg::spf_drive_t drive_o,
   input wire spf_pkg::spf_diag_t diag_o,
   input wire logic group_fault_indicator_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Trip seen through both sync flops
   sequence s_trip;
      $rose(self_prot_i) ##0 self_prot_i [*3];
   endsequence
   sequence s_estart_after_trip;
      s_trip ##2 emerg_start_i;
   endsequence
   property p_trip_sets;
      s_trip |-> ##[1:2] drive_o.sw_overload;
   endproperty
   a_trip_sets: assert property (p_trip_sets)
      else $error("overload flag missing after trip");
   property p_trip_off;
      drive_o.sw_overload |-> !drive_o.motor_en && !drive_o.brake_en;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("motor or brake on while overloaded");
   property p_trip_hold;
      drive_o.sw_overload && self_prot_i |=> drive_o.sw_overload;
   endproperty
   a_trip_hold: assert property (p_trip_hold)
      else $error("overload dropped while trip active");
   property p_estart;
      s_estart_after_trip |-> !drive_o.motor_en [*4];
   endproperty
   a_estart: assert property (p_estart)
      else $error("emergency start switched motor on");
   property p_s1;
      diag_o.s1 |-> diag_o.group_fault;
   endproperty
   a_s1: assert property (p_s1)
      else $error("status bit without group fault");
   property p_led;
      diag_o.group_fault |-> diag_o.fault_led_red && group_fault_indicator_o;
   endproperty
   a_led: assert property (p_led)
      else $error("indicator not red on group fault");
   property p_asym_rst;
      $fell(rst_i) |-> ##[0:2] diag_o.asym_en;
   endproperty
   a_asym_rst: assert property (p_asym_rst)
      else $error("asymmetry detection off after reset");
   property p_okay;
      hreadyout_o && !hresp_o;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus slave not ready or not okay");
endmodule : spf_checker

// File: verif/spf_master_model.sv
// Behavioural field-bus master: image, stop, bus error, fault list
module spf_master_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] image_i,
   input wire logic stop_i,
   input wire logic err_i,
   input wire logic s1_i,
   output logic [3:0] image_o,
   output logic stop_o,
   output logic err_o,
   output logic lpf_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         image_o <= 4'h0;
         stop_o <= 1'h0;
         err_o <= 1'h0;
      end else begin
         image_o <= image_i;
         stop_o <= stop_i;
         err_o <= err_i;
      end
   end
   // Fault list entry copies the slave status bit
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         lpf_o <= 1'h0;
      end else begin
         lpf_o <= s1_i;
      end
   end
endmodule : spf_master_model

// File: verif/tb_top.sv
// Self-checking bench for the parameter and fault-policy block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   logic hsel = 1'h0, hwrite = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, gfi, lpf, stop_in, err_in;
   logic prot = 1'h0, emerg = 1'h0, elec_ok = 1'h1, sw_ok = 1'h1;
   logic on_cmd = 1'h0, m_stop = 1'h0, m_err = 1'h0;
   logic [3:0] m_img = 4'h0, img_in, img_out;
   spf_pkg::spf_drive_t drv;
   spf_pkg::spf_diag_t dg;
   int n_fail = 0;
   int comparisons = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   spf_master_model u_master (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .image_i(m_img), .stop_i(m_stop), .err_i(m_err), .s1_i(dg.s1),
      .image_o(img_in), .stop_o(stop_in), .err_o(err_in), .lpf_o(lpf));
   // Short counts keep the data set timeout at 20 cycles
   spf_top #(.WAIT_TICKS_P(5), .TICK_CYC_P(4)) DUT (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .self_prot_i(prot), .emerg_start_i(emerg),
      .elec_sup_ok_i(elec_ok), .sw_sup_ok_i(sw_ok), .on_cmd_i(on_cmd),
      .master_stop_i(stop_in), .bus_err_i(err_in),
      .output_process_image_i(img_in), .output_process_image_o(img_out),
      .drive_o(drv), .diag_o(dg), .group_fault_indicator_o(gfi));
   task automatic complete_run;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk_sys_i);
      while (hreadyout !== 1'h1) begin
         n++;
         if (n > 50) begin
            n_fail++;
            complete_run();
         end
         @(posedge clk_sys_i);
      end
   endtask : wait_rdy
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   // Model flop plus three design edges, one spare
   task automatic wpin;
      repeat (5) @(posedge clk_sys_i);
   endtask : wpin
   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(nm, rd, exp);
   endtask : rc
   task automatic wc(input logic [31:0] d);
      bus(1'h1, spf_pkg::REG_CTRL, d);
      wpin();
   endtask : wc
   task automatic t_reset;
      rc("ctrl", spf_pkg::REG_CTRL, 32'(spf_pkg::CTRL_RST));
      rc("rated", spf_pkg::REG_RATED, 32'(spf_pkg::RATED_LO_MAX));
      rc("thresh", spf_pkg::REG_THRESH, 32'(spf_pkg::PCT_FULL));
      rc("limit", spf_pkg::REG_LIMIT, 32'(spf_pkg::RATED_LO_MAX));
      rc("unmapped", 8'h40, 32'h0);
      chk("asym", {31'h0, dg.asym_en}, 32'h1);
   endtask : t_reset
   task automatic t_rated;
      bus(1'h1, spf_pkg::REG_RATED, 32'h5);
      rc("rmin", spf_pkg::REG_RATED, 32'(spf_pkg::RATED_LO_MIN));
      bus(1'h1, spf_pkg::REG_RATED, 32'h1388);
      rc("rmax", spf_pkg::REG_RATED, 32'(spf_pkg::RATED_LO_MAX));
      wc(32'h282);
      rc("rhi", spf_pkg::REG_RATED, 32'(spf_pkg::RATED_HI_MAX));
      wc(32'h382);
      bus(1'h1, spf_pkg::REG_RATED, 32'h4b0);
      rc("rdir", spf_pkg::REG_RATED, 32'(spf_pkg::RATED_DIRECT_MAX));
      bus(1'h1, spf_pkg::REG_THRESH, 32'h32);
      rc("lim", spf_pkg::REG_LIMIT, 32'(spf_pkg::RATED_DIRECT_MAX) / 2);
      wc(32'h203);
      chk("asym1", {31'h0, dg.asym_en}, 32'h0);
      wc(32'h202);
      chk("asym3", {31'h0, dg.asym_en}, 32'h1);
   endtask : t_rated
   task automatic t_stop;
      m_img <= 4'ha;
      wpin();
      chk("img", {28'h0, img_out}, 32'ha);
      m_stop <= 1'h1;
      wpin();
      chk("img_stop", {28'h0, img_out}, 32'h0);
      m_stop <= 1'h0;
      m_err <= 1'h1;
      wpin();
      chk("img_err", {28'h0, img_out}, 32'h0);
      // Retain chosen before the error; a new image must not pass
      m_err <= 1'h0;
      wc(32'h212);
      chk("img_back", {28'h0, img_out}, 32'ha);
      m_err <= 1'h1;
      m_img <= 4'h5;
      wpin();
      chk("img_keep", {28'h0, img_out}, 32'ha);
      wc(32'h002);
      chk("img_man", {28'h0, img_out}, 32'h5);
      m_err <= 1'h0;
      wc(32'h202);
   endtask : t_stop
   task automatic t_supply;
      sw_ok <= 1'h0;
      wpin();
      // Fault list entry lags the status bit by one master edge
      @(posedge clk_sys_i);
      chk("gf", {28'h0, dg.group_fault, dg.s1, gfi, lpf}, 32'hf);
      wc(32'h20a);
      chk("warn", {30'h0, dg.group_fault, dg.group_warn}, 32'h1);
      wc(32'h206);
      chk("no_on", {31'h0, dg.group_fault}, 32'h0);
      on_cmd <= 1'h1;
      wpin();
      chk("on", {30'h0, dg.group_fault, gfi}, 32'h3);
      wc(32'h226);
      chk("block", {30'h0, dg.s1, gfi}, 32'h1);
      sw_ok <= 1'h1;
      on_cmd <= 1'h0;
      wc(32'h202);
   endtask : t_supply
   task automatic t_trip;
      emerg <= 1'h1;
      on_cmd <= 1'h1;
      prot <= 1'h1;
      wpin();
      chk("trip", {29'h0, drv}, 32'h1);
      prot <= 1'h0;
      wpin();
      chk("estart", {29'h0, drv}, 32'h1);
      elec_ok <= 1'h0;
      wpin();
      elec_ok <= 1'h1;
      wpin();
      bus(1'h0, spf_pkg::REG_STAT, 32'h0);
      chk("ovl_keep", {31'h0, rd[5]}, 32'h1);
      wc(32'h200);
      elec_ok <= 1'h0;
      wpin();
      elec_ok <= 1'h1;
      wpin();
      bus(1'h0, spf_pkg::REG_STAT, 32'h0);
      chk("ovl_clr", {31'h0, rd[5]}, 32'h0);
      emerg <= 1'h0;
      on_cmd <= 1'h0;
      wc(32'h202);
   endtask : t_trip
   task automatic t_wait;
      // Timeout ran out long ago, so the fault shows at once
      wc(32'h242);
      chk("pfault", {31'h0, dg.param_fault}, 32'h1);
      wc(32'h642);
      chk("pclear", {31'h0, dg.param_fault}, 32'h0);
   endtask : t_wait
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      @(posedge clk_sys_i);
      t_reset();
      t_rated();
      t_stop();
      t_supply();
      t_trip();
      t_wait();
      complete_run();
   end
endmodule : tb_top

bind spf_top spf_checker #(.WAIT_TICKS_P(WAIT_TICKS_P),
   .TICK_CYC_P(TICK_CYC_P)) u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .self_prot_i(self_prot_i),
   .emerg_start_i(emerg_start_i), .drive_o(drive_o), .diag_o(diag_o),
   .group_fault_indicator_o(group_fault_indicator_o));
